// ---- core/oap_pkg.sv ----
package oap_pkg;
    // serial frame: read flag, 7-bit address, 8-bit data, msb first
    localparam int unsigned OAP_FRAME_BITS = 16;
    localparam int unsigned OAP_HDR_BITS = 8;
    localparam int unsigned OAP_READ_BIT = 7;
    localparam int unsigned OAP_REG_COUNT = 4;
    localparam int unsigned OAP_REG_WIDTH = 8;
    // mode register addresses within a group
    localparam logic [1:0] OAP_ADDR_POWER = 2'h0;
    localparam logic [1:0] OAP_ADDR_OUTPUT = 2'h1;
    localparam logic [1:0] OAP_ADDR_SERIAL = 2'h2;
    // field positions
    localparam int unsigned OAP_POWER_DOWN_BIT = 0;
    localparam int unsigned OAP_ONE_LANE_BIT = 0;
    localparam int unsigned OAP_HALF_CURRENT_BIT = 1;
    localparam int unsigned OAP_TERM_ON_BIT = 2;
    localparam int unsigned OAP_WIDTH_LSB = 0;
    localparam logic [31:0] OAP_REGS_RESET = 32'h0000_0000;
    // serialization width codes
    localparam logic [1:0] OAP_WIDTH_16 = 2'h0;
    localparam logic [1:0] OAP_WIDTH_14 = 2'h1;
    localparam logic [1:0] OAP_WIDTH_12 = 2'h2;
    localparam int unsigned OAP_SAMPLE_BITS = 16;
    localparam int unsigned OAP_CHANNELS = 8;
    localparam int unsigned OAP_GROUP_CH [2][4] = '{'{0, 3, 4, 7}, '{1, 2, 5, 6}};
    // synchronised pin vector positions
    localparam int unsigned OAP_PIN_STYLE = 0;
    localparam int unsigned OAP_PIN_SEL1 = 1;
    localparam int unsigned OAP_PIN_SEL2 = 2;
    localparam int unsigned OAP_PIN_SCK = 3;
    localparam int unsigned OAP_PIN_SDI = 4;
    localparam int unsigned OAP_PIN_RB1 = 5;
    localparam int unsigned OAP_PIN_RB2 = 6;
    localparam int unsigned OAP_PIN_ENCP = 7;
    localparam int unsigned OAP_PIN_ENCN = 8;
    localparam int unsigned OAP_PIN_TGL1 = 9;
    localparam int unsigned OAP_PIN_TGL2 = 10;
    localparam int unsigned OAP_PIN_COUNT = 11;
    // far side must keep the lane bit period at or above this
    localparam int unsigned OAP_SERIAL_BIT_PERIOD_MIN_PS = 1000;

    typedef struct packed {
        logic power_down;
        logic one_lane;
        logic half_current;
        logic term_on;
        logic [1:0] width;
    } oap_cfg_s;

    typedef struct packed {
        logic [3:0] lane_a;
        logic [3:0] lane_b;
        logic frame;
        logic bit_clk;
        logic active;
        logic [4:0] idx;
    } oap_ser_s;
endpackage

// ---- core/oap_top.sv ----
`timescale 1ns/1ns
module oap_group_port (
    input wire logic reset_i,
    input wire logic prog_clock_i,
    input wire logic select_n_i,
    input wire logic prog_data_i,
    output logic [31:0] regs_o,
    output logic update_tgl_o,
    output logic readback_oe_o
);
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [14:0] shift, next_shift;
    logic [7:0] hdr, next_hdr;
    logic [3:0][7:0] regs, next_regs;
    logic tgl, next_tgl;
    logic rb_bit, next_rb_bit;
    logic [7:0] rd_word;

    always_comb begin
        next_bit_cnt = (bit_cnt == 5'(oap_pkg::OAP_FRAME_BITS)) ? bit_cnt : bit_cnt + 5'h01;
        next_shift = {shift[13:0], prog_data_i};
        next_hdr = hdr;
        if (bit_cnt == 5'(oap_pkg::OAP_HDR_BITS - 1)) begin
            next_hdr = {shift[6:0], prog_data_i};
        end
        next_regs = regs;
        next_tgl = tgl;
        // commit on the last bit; out-of-range addresses are dropped
        if (bit_cnt == 5'(oap_pkg::OAP_FRAME_BITS - 1) && !hdr[oap_pkg::OAP_READ_BIT]
            && hdr[6:2] == 5'h00) begin
            next_regs[hdr[1:0]] = {shift[6:0], prog_data_i};
            next_tgl = ~tgl;
        end
        rd_word = regs[hdr[1:0]];
        next_rb_bit = 1'b1;
        if (hdr[oap_pkg::OAP_READ_BIT] && bit_cnt >= 5'(oap_pkg::OAP_HDR_BITS)
            && bit_cnt < 5'(oap_pkg::OAP_FRAME_BITS)) begin
            next_rb_bit = rd_word[3'(5'h0F - bit_cnt)];
        end
    end

    // a raised select ends the frame without needing a clock edge
    always_ff @(posedge prog_clock_i or posedge reset_i or posedge select_n_i) begin
        if (reset_i || select_n_i) begin
            bit_cnt <= 5'h00;
            shift <= 15'h0000;
            hdr <= 8'h00;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            hdr <= next_hdr;
        end
    end

    always_ff @(posedge prog_clock_i or posedge reset_i) begin
        if (reset_i) begin
            regs <= oap_pkg::OAP_REGS_RESET;
            tgl <= 1'b0;
        end else begin
            regs <= next_regs;
            tgl <= next_tgl;
        end
    end

    always_ff @(negedge prog_clock_i or posedge reset_i or posedge select_n_i) begin
        if (reset_i || select_n_i) begin
            rb_bit <= 1'b1;
        end else begin
            rb_bit <= next_rb_bit;
        end
    end

    assign regs_o = regs;
    assign update_tgl_o = tgl;
    assign readback_oe_o = ~rb_bit; // open drain: only pulls low

    idle_hold_a: assert property (@(posedge prog_clock_i) disable iff (reset_i)
        select_n_i |=> $stable(regs))
        else $error("mode registers changed while deselected");
    write_commit_a: assert property (@(posedge prog_clock_i) disable iff (reset_i)
        (bit_cnt == 5'h0F && !select_n_i && !hdr[7] && hdr[6:2] == 5'h00)
        |=> regs[$past(hdr[1:0])] == $past({shift[6:0], prog_data_i}))
        else $error("frame not committed to addressed register");
endmodule // oap_group_port

// Summary of operation
// - select one owns channels 1, 4, 5, 8
// - select two owns channels 2, 3, 6, 7
// - shift only while own select held low
// - capture data on serial clock rising edge
// - parallel: select level picks lane count
// - parallel: serial clock level picks current
// - parallel: data pin level powers down
// - conversion starts on encode rising edge
// - 16, 14, 12-bit serialization, both lanes
// - two-lane 14-bit: frame period two encodes
// - one-lane: second lane off, all bits first
// - readback on open-drain output, falling edges
// - strap low serial, high parallel
// - parallel: readback pin enables termination
module oap_top (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic prog_clock_i,
    input wire logic program_style_select_i,
    input wire logic group_one_select_n_i,
    input wire logic group_two_select_n_i,
    input wire logic prog_data_i,
    input wire logic group_one_readback_in_i,
    output logic group_one_readback_out_o,
    output logic group_one_readback_oe_o,
    input wire logic group_two_readback_in_i,
    output logic group_two_readback_out_o,
    output logic group_two_readback_oe_o,
    input wire logic encode_clock_pos_i,
    input wire logic encode_clock_neg_i,
    input wire logic [7:0][15:0] sample_i,
    output wire logic [7:0] lane_a_o,
    output wire logic [7:0] lane_b_o,
    output logic [1:0] frame_start_out_o,
    output logic [1:0] serial_bit_clock_out_o,
    output oap_pkg::oap_cfg_s [1:0] group_cfg_o,
    output logic serial_mode_o
);
    localparam int unsigned NP = oap_pkg::OAP_PIN_COUNT;
    logic [1:0][31:0] regs_sck;
    logic [1:0] tgl_sck;
    logic [1:0] oe_sck;
    logic [NP-1:0] pin_raw, sync1, sync2;
    logic [1:0] tgl_prev, next_tgl_prev;
    logic enc_prev, next_enc_prev;
    logic [1:0][31:0] words, next_words;
    oap_pkg::oap_cfg_s [1:0] cfg, next_cfg;
    logic enc_lvl, start, par;
    logic [1:0] tgl_edge, sel_s, rb_s;
    oap_pkg::oap_ser_s [1:0] ser;

    oap_group_port u_group_one (
        .reset_i(reset_i),
        .prog_clock_i(prog_clock_i),
        .select_n_i(group_one_select_n_i),
        .prog_data_i(prog_data_i),
        .regs_o(regs_sck[0]),
        .update_tgl_o(tgl_sck[0]),
        .readback_oe_o(oe_sck[0])
    );
    oap_group_port u_group_two (
        .reset_i(reset_i),
        .prog_clock_i(prog_clock_i),
        .select_n_i(group_two_select_n_i),
        .prog_data_i(prog_data_i),
        .regs_o(regs_sck[1]),
        .update_tgl_o(tgl_sck[1]),
        .readback_oe_o(oe_sck[1])
    );

    assign pin_raw = {tgl_sck[1], tgl_sck[0], encode_clock_neg_i, encode_clock_pos_i,
        group_two_readback_in_i, group_one_readback_in_i, prog_data_i, prog_clock_i,
        group_two_select_n_i, group_one_select_n_i, program_style_select_i};

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
        end
    end

    assign par = sync2[oap_pkg::OAP_PIN_STYLE];
    assign sel_s = {sync2[oap_pkg::OAP_PIN_SEL2], sync2[oap_pkg::OAP_PIN_SEL1]};
    assign rb_s = {sync2[oap_pkg::OAP_PIN_RB2], sync2[oap_pkg::OAP_PIN_RB1]};
    // rising positive is the falling complement; both must agree
    assign enc_lvl = sync2[oap_pkg::OAP_PIN_ENCP] & ~sync2[oap_pkg::OAP_PIN_ENCN];
    assign start = enc_lvl & ~enc_prev;
    assign tgl_edge = {sync2[oap_pkg::OAP_PIN_TGL2], sync2[oap_pkg::OAP_PIN_TGL1]} ^ tgl_prev;

    // parallel mode never drives the readback pins: they are inputs then
    assign group_one_readback_out_o = 1'b0;
    assign group_two_readback_out_o = 1'b0;
    assign group_one_readback_oe_o = oe_sck[0] & ~program_style_select_i;
    assign group_two_readback_oe_o = oe_sck[1] & ~program_style_select_i;

    always_comb begin
        next_enc_prev = enc_lvl;
        next_tgl_prev = {sync2[oap_pkg::OAP_PIN_TGL2], sync2[oap_pkg::OAP_PIN_TGL1]};
        next_words = words;
        for (int g = 0; g < 2; g++) begin
            // words are stable for a whole frame after the toggle moves
            if (tgl_edge[g]) begin
                next_words[g] = regs_sck[g];
            end
            if (par) begin
                next_cfg[g].power_down = sync2[oap_pkg::OAP_PIN_SDI];
                next_cfg[g].one_lane = sel_s[g];
                next_cfg[g].half_current = sync2[oap_pkg::OAP_PIN_SCK];
                next_cfg[g].term_on = rb_s[g];
                next_cfg[g].width = oap_pkg::OAP_WIDTH_16;
            end else begin
                next_cfg[g].power_down =
                    words[g][8 * oap_pkg::OAP_ADDR_POWER + oap_pkg::OAP_POWER_DOWN_BIT];
                next_cfg[g].one_lane =
                    words[g][8 * oap_pkg::OAP_ADDR_OUTPUT + oap_pkg::OAP_ONE_LANE_BIT];
                next_cfg[g].half_current =
                    words[g][8 * oap_pkg::OAP_ADDR_OUTPUT + oap_pkg::OAP_HALF_CURRENT_BIT];
                next_cfg[g].term_on =
                    words[g][8 * oap_pkg::OAP_ADDR_OUTPUT + oap_pkg::OAP_TERM_ON_BIT];
                next_cfg[g].width =
                    words[g][8 * oap_pkg::OAP_ADDR_SERIAL + oap_pkg::OAP_WIDTH_LSB +: 2];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            enc_prev <= 1'b0;
            tgl_prev <= 2'h0;
            words <= '0;
            cfg <= '0;
        end else begin
            enc_prev <= next_enc_prev;
            tgl_prev <= next_tgl_prev;
            words <= next_words;
            cfg <= next_cfg;
        end
    end

    assign group_cfg_o = cfg;
    assign serial_mode_o = ~par;

    for (genvar g = 0; g < 2; g++) begin : g_ser
        oap_pkg::oap_ser_s next_ser;
        logic [3:0][15:0] sh_a, sh_b, next_sh_a, next_sh_b;
        logic [4:0] bits, nb;
        logic mode14;

        always_comb begin
            bits = 5'(oap_pkg::OAP_SAMPLE_BITS) - {2'h0, cfg[g].width, 1'b0};
            nb = cfg[g].one_lane ? bits : {1'b0, bits[4:1]};
            mode14 = !cfg[g].one_lane && cfg[g].width == oap_pkg::OAP_WIDTH_14;
            next_ser = ser[g];
            next_sh_a = sh_a;
            next_sh_b = sh_b;
            if (cfg[g].power_down) begin
                next_ser.active = 1'b0;
                next_ser.frame = 1'b0;
                next_ser.idx = 5'h00;
            end else if (start) begin
                for (int c = 0; c < 4; c++) begin
                    next_sh_a[c] = sample_i[oap_pkg::OAP_GROUP_CH[g][c]];
                    next_sh_b[c] = sample_i[oap_pkg::OAP_GROUP_CH[g][c]] << nb;
                end
                next_ser.active = 1'b1;
                next_ser.idx = 5'h00;
                // 14-bit two-lane frame spans two conversions
                next_ser.frame = mode14 ? ~ser[g].frame : 1'b1;
            end else if (ser[g].active) begin
                for (int c = 0; c < 4; c++) begin
                    next_sh_a[c] = {sh_a[c][14:0], 1'b0};
                    next_sh_b[c] = {sh_b[c][14:0], 1'b0};
                end
                next_ser.idx = ser[g].idx + 5'h01;
                next_ser.active = (ser[g].idx + 5'h01) < nb;
                if (!mode14) begin
                    next_ser.frame = next_ser.active && (next_ser.idx < {1'b0, nb[4:1]});
                end
            end
            next_ser.bit_clk = next_ser.active ? ~ser[g].bit_clk : 1'b0;
            for (int c = 0; c < 4; c++) begin
                next_ser.lane_a[c] = next_ser.active & next_sh_a[c][15];
                next_ser.lane_b[c] = next_ser.active & ~cfg[g].one_lane
                    & next_sh_b[c][15];
            end
        end

        always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
                ser[g] <= '0;
                sh_a <= '0;
                sh_b <= '0;
            end else begin
                ser[g] <= next_ser;
                sh_a <= next_sh_a;
                sh_b <= next_sh_b;
            end
        end

        for (genvar c = 0; c < 4; c++) begin : g_map
            assign lane_a_o[oap_pkg::OAP_GROUP_CH[g][c]] = ser[g].lane_a[c];
            assign lane_b_o[oap_pkg::OAP_GROUP_CH[g][c]] = ser[g].lane_b[c];
        end
        assign frame_start_out_o[g] = ser[g].frame;
        assign serial_bit_clock_out_o[g] = ser[g].bit_clk;

        lane_b_off_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
            cfg[g].one_lane |=> ser[g].lane_b == 4'h0)
            else $error("second lane active in one-lane mode");
        frame_toggle_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
            (start && mode14 && !cfg[g].power_down) |=> ser[g].frame != $past(ser[g].frame))
            else $error("frame did not toggle on conversion in 14-bit two-lane mode");
        bit_count_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
            (ser[g].active && ser[g].idx == nb - 5'h01 && !start && !cfg[g].power_down
                && $stable(cfg[g]))
            |=> !ser[g].active)
            else $error("serializer ran past its bit count");
        start_load_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
            (start && !cfg[g].power_down) |=> ser[g].active && ser[g].idx == 5'h00)
            else $error("conversion start did not load serializer");
    end

    lane_par_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        par |=> cfg[0].one_lane == $past(sel_s[0]) && cfg[1].one_lane == $past(sel_s[1]))
        else $error("parallel lane mode does not follow select level");
    drive_par_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        par |=> cfg[0].half_current == $past(sync2[oap_pkg::OAP_PIN_SCK]))
        else $error("parallel drive current does not follow clock pin");
    power_par_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (par && sync2[oap_pkg::OAP_PIN_SDI]) |=> cfg[0].power_down && cfg[1].power_down
        ##1 frame_start_out_o == 2'h0)
        else $error("parallel power down not applied");
    term_par_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        par |=> cfg[1].term_on == $past(rb_s[1]))
        else $error("termination does not follow readback pin");
    no_drive_par_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        program_style_select_i |-> !group_one_readback_oe_o && !group_two_readback_oe_o)
        else $error("readback pin driven in parallel mode");

    serial_write_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        !par && tgl_edge[0]);
    par_power_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        par && cfg[0].power_down);
    one_lane_12_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[1].one_lane && cfg[1].width == oap_pkg::OAP_WIDTH_12 && ser[1].active);
    frame_14_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        start && !cfg[0].one_lane && cfg[0].width == oap_pkg::OAP_WIDTH_14);
endmodule // oap_top

// ---- sim/oap_host_model.sv ----
`timescale 1ns/1ns
module oap_host_model (
    output logic prog_clock_o,
    output logic sel1_n_o,
    output logic sel2_n_o,
    output logic data_o,
    input wire logic rb1_i,
    input wire logic rb2_i
);
    localparam int HALF = 80;
    logic [7:0] rd_data;
    initial begin
        prog_clock_o = 1'b0;
        sel1_n_o = 1'b1;
        sel2_n_o = 1'b1;
        data_o = 1'b0;
        rd_data = 8'h00;
    end
    // fewer than 16 bits aborts by raising the select early
    task automatic frame(input int g, input logic [15:0] word, input int nbits);
        #7;
        rd_data = 8'h00;
        if (g == 0) sel1_n_o = 1'b0; // select held low over the whole frame
        else sel2_n_o = 1'b0;
        #(HALF / 2);
        for (int i = 0; i < nbits; i++) begin
            data_o = word[15 - i]; // changes only while clock low
            #HALF prog_clock_o = 1'b1;
            #HALF;
            // taken just ahead of the falling edge
            if (i >= 8) rd_data = {rd_data[6:0], (g == 0) ? rb1_i : rb2_i};
            prog_clock_o = 1'b0;
        end
        #(HALF / 2);
        sel1_n_o = 1'b1;
        sel2_n_o = 1'b1;
        data_o = ~data_o; // released line: no stale value
    endtask
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            data_o = ~data_o;
            #HALF prog_clock_o = 1'b1;
            #HALF prog_clock_o = 1'b0;
        end
    endtask
    task automatic set_static(input logic s1, input logic s2, input logic sck, input logic sdi);
        sel1_n_o = s1;
        sel2_n_o = s2;
        prog_clock_o = sck;
        data_o = sdi;
    endtask
endmodule // oap_host_model

// ---- sim/oap_top_tb.sv ----
`timescale 1ns/1ns
module oap_top_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b0;
    logic strap = 1'b0;
    logic enc_p = 1'b0;
    logic enc_n = 1'b1;
    logic term1 = 1'b0;
    logic term2 = 1'b0;
    logic [7:0][15:0] sample = '0;
    wire sck, s1, s2, sdi, rb1_oe, rb2_oe, smode, rb1_pin, rb2_pin, rb1_out, rb2_out;
    wire [7:0] lane_a, lane_b;
    wire [1:0] frame, bclk;
    oap_pkg::oap_cfg_s [1:0] cfg;
    int n_fail = 0;
    int samples_checked = 0;
    // pull-up on the open-drain pins; parallel mode drives them as inputs
    assign rb1_pin = strap ? term1 : (rb1_oe ? rb1_out : 1'b1);
    assign rb2_pin = strap ? term2 : (rb2_oe ? rb2_out : 1'b1);
    // one lane bit per 40 ns clock keeps the bit period far above 1 ns
    always #20 sys_clk = ~sys_clk;
    oap_host_model i_oap_host_model (.prog_clock_o(sck), .sel1_n_o(s1), .sel2_n_o(s2),
        .data_o(sdi), .rb1_i(rb1_pin), .rb2_i(rb2_pin));
    oap_top i_oap_top (.sys_clk_i(sys_clk), .reset_i(reset), .prog_clock_i(sck),
        .program_style_select_i(strap), .group_one_select_n_i(s1),
        .group_two_select_n_i(s2), .prog_data_i(sdi), .group_one_readback_in_i(rb1_pin),
        .group_one_readback_out_o(rb1_out), .group_one_readback_oe_o(rb1_oe),
        .group_two_readback_in_i(rb2_pin), .group_two_readback_out_o(rb2_out),
        .group_two_readback_oe_o(rb2_oe), .encode_clock_pos_i(enc_p),
        .encode_clock_neg_i(enc_n), .sample_i(sample), .lane_a_o(lane_a), .lane_b_o(lane_b),
        .frame_start_out_o(frame), .serial_bit_clock_out_o(bclk), .group_cfg_o(cfg),
        .serial_mode_o(smode));
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // cfg packed as {power_down, one_lane, half_current, term_on, width}
    task automatic chk_cfg(input int g, input logic [5:0] exp);
        samples_checked++;
        if (cfg[g] !== exp) begin
            n_fail++;
            $display("[FAIL] cfg%0d expected %h seen %h", g, exp, cfg[g]);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input int g, input logic [1:0] a, input logic [7:0] d);
        i_oap_host_model.frame(g, {1'b0, 5'h00, a, d}, 16);
        cyc(8); // crossing into the system domain takes a few cycles
    endtask
    task automatic rd(input int g, input logic [1:0] a, input logic [7:0] exp);
        i_oap_host_model.frame(g, {1'b1, 5'h00, a, 8'h00}, 16);
        chk("readback", exp, i_oap_host_model.rd_data);
        cyc(8);
    endtask
    task automatic conv(input int ch, input int nb, input logic two, output logic fr);
        int g;
        int k;
        logic lb;
        g = (ch == 1 || ch == 2 || ch == 5 || ch == 6) ? 1 : 0;
        enc_p = 1'b1;
        enc_n = 1'b0;
        k = 0;
        while (bclk[g] !== 1'b1 && k < 10) begin
            cyc(1);
            k++;
        end
        chk("start", 8'h01, {7'h00, bclk[g]});
        chk("start_latency", 8'h03, k[7:0]);
        fr = frame[g];
        for (int i = 0; i < nb; i++) begin
            lb = 1'b0;
            if (two) lb = sample[ch][15 - nb - i];
            chk("lane_a", {7'h00, sample[ch][15 - i]}, {7'h00, lane_a[ch]});
            chk("lane_b", {7'h00, lb}, {7'h00, lane_b[ch]});
            chk("bit_clock", {7'h00, ~i[0]}, {7'h00, bclk[g]});
            cyc(1);
        end
        chk("word_end", 8'h00, {6'h00, bclk[g], lane_a[ch]});
        enc_p = 1'b0;
        enc_n = 1'b1;
        cyc(8);
    endtask
    task automatic t_groups();
        chk("serial_mode", 8'h01, {7'h00, smode});
        chk_cfg(0, 6'h00);
        wr(0, oap_pkg::OAP_ADDR_OUTPUT, 8'h07);
        chk_cfg(0, 6'h1C);
        chk_cfg(1, 6'h00);
        wr(1, oap_pkg::OAP_ADDR_SERIAL, 8'h01);
        chk_cfg(1, 6'h01);
        chk_cfg(0, 6'h1C);
        rd(0, oap_pkg::OAP_ADDR_OUTPUT, 8'h07);
        rd(1, oap_pkg::OAP_ADDR_SERIAL, 8'h01);
    endtask
    task automatic t_ignore();
        i_oap_host_model.idle_clocks(20);
        cyc(8);
        chk_cfg(0, 6'h1C);
        chk_cfg(1, 6'h01);
        i_oap_host_model.frame(0, {1'b0, 5'h00, oap_pkg::OAP_ADDR_OUTPUT, 8'h00}, 10);
        cyc(8);
        chk_cfg(0, 6'h1C);
    endtask
    task automatic t_serial();
        logic fr0;
        logic fr1;
        for (int w = 0; w < 3; w++) begin
            for (int one = 0; one < 2; one++) begin
                wr(0, oap_pkg::OAP_ADDR_SERIAL, {6'h00, w[1:0]});
                wr(0, oap_pkg::OAP_ADDR_OUTPUT, {7'h00, one[0]});
                conv(0, (16 - 2 * w) >> (1 - one), one == 0, fr0);
                if (!(w == 1 && one == 0)) chk("frame", 8'h01, {7'h00, fr0});
            end
        end
        // group two still two-lane, 14 bits: frame flips each conversion
        conv(6, 7, 1'b1, fr0);
        conv(6, 7, 1'b1, fr1);
        chk("frame_toggle", {7'h00, ~fr0}, {7'h00, fr1});
        // serial power down stops group one only
        wr(0, oap_pkg::OAP_ADDR_POWER, 8'h01);
        chk_cfg(0, 6'h32);
        chk_cfg(1, 6'h01);
        enc_p = 1'b1;
        enc_n = 1'b0;
        cyc(3);
        chk("group_off", 8'h04, {5'h00, bclk[1], bclk[0], lane_a[0]});
        enc_p = 1'b0;
        enc_n = 1'b1;
        cyc(8);
    endtask
    task automatic t_parallel();
        reset = 1'b1;
        strap = 1'b1;
        term1 = 1'b1;
        i_oap_host_model.set_static(1'b1, 1'b0, 1'b1, 1'b0);
        cyc(4);
        reset = 1'b0;
        cyc(8);
        chk("serial_mode", 8'h00, {7'h00, smode});
        chk("rb_oe", 8'h00, {6'h00, rb2_oe, rb1_oe});
        chk_cfg(0, 6'h1C);
        chk_cfg(1, 6'h08);
        i_oap_host_model.set_static(1'b0, 1'b1, 1'b0, 1'b1);
        cyc(8);
        chk_cfg(0, 6'h24);
        chk_cfg(1, 6'h30);
        enc_p = 1'b1;
        enc_n = 1'b0;
        repeat (12) begin
            cyc(1);
            chk("lanes_off", 8'h00, lane_a | lane_b | {6'h00, frame});
        end
        enc_p = 1'b0;
        enc_n = 1'b1;
    endtask
    initial begin
        #2_000_000;
        n_fail++;
        end_sim();
    end
    initial begin
        for (int i = 0; i < 8; i++) sample[i] = 16'hC3A5 ^ (16'h1357 * i[15:0]);
        @(negedge sys_clk);
        // a real edge, so the link-clock flops are cleared as well
        reset = 1'b1;
        cyc(20);
        reset = 1'b0;
        cyc(4);
        t_groups();
        t_ignore();
        t_serial();
        t_parallel();
        end_sim();
    end
endmodule // oap_top_tb
